// [core/bds_port.sv]
// Burst-of-two DDR SRAM port: pin sampling, write capture, read drive, echo strobes
`timescale 1ns/1ns
module bds_port
    import bds_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Memory-side clock pins and mode strap
    input wire bds_clks_t clks_i,
    // Control, address, byte selects and data-in pins
    input wire bds_pins_t pins_i,
    // Data-out pins
    output logic [DATA_W-1:0] dq_o,
    output logic dq_oe_o,
    // Echo strobes
    output logic echo_strobe_o,
    output logic echo_strobe_n_o
);
    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    // Data rides the same two stages as the clocks so an edge and its beat align
    bds_clks_t clk_s1_reg, clk_s2_reg, clk_s3_reg;
    bds_pins_t pin_s1_reg, pin_s2_reg;
    bds_clks_t clk_s1_next, clk_s2_next, clk_s3_next;
    bds_pins_t pin_s1_next, pin_s2_next;

    always_comb begin
        clk_s1_next = clks_i;
        clk_s2_next = clk_s1_reg;
        clk_s3_next = clk_s2_reg;
        pin_s1_next = pins_i;
        pin_s2_next = pin_s1_reg;
    end

    always_ff @(posedge ref_clk_i) begin
        clk_s1_reg <= clk_s1_next;
        clk_s2_reg <= clk_s2_next;
        clk_s3_reg <= clk_s3_next;
        pin_s1_reg <= pin_s1_next;
        pin_s2_reg <= pin_s2_next;
    end

    logic k_rise, kn_rise, out_rise0, out_rise1, single;
    logic read_load, write_load;

    always_comb begin
        single = clk_s2_reg.single_clock;
        k_rise = clk_s2_reg.cap_clk & ~clk_s3_reg.cap_clk;
        kn_rise = clk_s2_reg.cap_clk_n & ~clk_s3_reg.cap_clk_n;
        out_rise0 = single ? k_rise : (clk_s2_reg.out_clk & ~clk_s3_reg.out_clk);
        out_rise1 = single ? kn_rise : (clk_s2_reg.out_clk_n & ~clk_s3_reg.out_clk_n);
        // Load high means deselected: address is never looked at then
        read_load = k_rise & ~pin_s2_reg.load_strobe_n & pin_s2_reg.rd_wrn;
        write_load = k_rise & ~pin_s2_reg.load_strobe_n & ~pin_s2_reg.rd_wrn;
    end

    // ------------------------------------------------------------------------
    // Write capture and array access
    // ------------------------------------------------------------------------
    logic wr_pend_reg, wr_pend_next;
    logic [ADDR_W-1:0] wr_addr_reg, wr_addr_next;
    logic [ARRAYS-1:0] arr_en, arr_we;
    logic [LANES-1:0] lane_we;
    logic [IDX_W-1:0] arr_idx;
    logic [DATA_W-1:0] arr_wdata;
    logic [DATA_W-1:0] arr_rdata [ARRAYS];
    logic [ADDR_W-1:0] beat_addr;

    always_comb begin
        wr_pend_next = wr_pend_reg;
        wr_addr_next = wr_addr_reg;
        arr_en = '0;
        arr_we = '0;
        lane_we = '0;
        arr_idx = pin_s2_reg.addr[ADDR_W-1:1];
        arr_wdata = pin_s2_reg.data;
        beat_addr = bds_burst_addr(wr_addr_reg, 1'b1);
        if (read_load) begin
            arr_en = '1;
            wr_pend_next = 1'b0;
        end else if (write_load) begin
            // First beat goes to the array named by the burst start bit
            beat_addr = bds_burst_addr(pin_s2_reg.addr, 1'b0);
            arr_en[beat_addr[0]] = 1'b1;
            arr_we[beat_addr[0]] = 1'b1;
            lane_we = ~pin_s2_reg.byte_write_select_n;
            wr_pend_next = 1'b1;
            wr_addr_next = pin_s2_reg.addr;
        end else if (wr_pend_reg && kn_rise) begin
            arr_idx = beat_addr[ADDR_W-1:1];
            arr_en[beat_addr[0]] = 1'b1;
            arr_we[beat_addr[0]] = 1'b1;
            lane_we = ~pin_s2_reg.byte_write_select_n;
            wr_pend_next = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
        end
    end

    for (genvar g = 0; g < ARRAYS; g++) begin : g_arr
        bds_array #(
            .WIDTH(DATA_W),
            .LANES(LANES),
            .DEPTH(ARRAY_DEPTH)
        ) u_array (
            .ref_clk_i(ref_clk_i),
            .en_i(arr_en[g]),
            .we_i(arr_we[g]),
            .lane_we_i(lane_we),
            .idx_i(arr_idx),
            .wdata_i(arr_wdata),
            .rdata_o(arr_rdata[g])
        );
    end

    // ------------------------------------------------------------------------
    // Read fetch and output sequencing
    // ------------------------------------------------------------------------
    logic fetch_reg, fetch_next;
    logic rd_bit_reg, rd_bit_next;
    logic rd_pend_reg, rd_pend_next;
    logic [DATA_W-1:0] q_beat0_reg, q_beat0_next, q_beat1_reg, q_beat1_next;
    logic [DATA_W-1:0] dq_reg, dq_next;
    // Second beat is parked when the first leaves: a back-to-back fetch refills q early
    logic [DATA_W-1:0] b1_hold_reg, b1_hold_next;
    bds_out_state_t state_reg, state_next;
    logic consume;

    always_comb begin
        fetch_next = read_load;
        rd_bit_next = read_load ? pin_s2_reg.addr[0] : rd_bit_reg;
        q_beat0_next = q_beat0_reg;
        q_beat1_next = q_beat1_reg;
        if (fetch_reg) begin
            q_beat0_next = arr_rdata[rd_bit_reg];
            q_beat1_next = arr_rdata[~rd_bit_reg];
        end
        consume = 1'b0;
        state_next = state_reg;
        dq_next = dq_reg;
        b1_hold_next = b1_hold_reg;
        unique case (state_reg)
            ST_IDLE, ST_BEAT1: begin
                if (out_rise0) begin
                    if (rd_pend_reg) begin
                        consume = 1'b1;
                        dq_next = q_beat0_reg;
                        b1_hold_next = q_beat1_reg;
                        state_next = ST_BEAT0;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_BEAT0: begin
                if (out_rise1) begin
                    dq_next = b1_hold_reg;
                    state_next = ST_BEAT1;
                end
            end
        endcase
        // A new fetch in the cycle a beat is taken still counts
        rd_pend_next = (rd_pend_reg & ~consume) | fetch_reg;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            fetch_reg <= 1'b0;
            rd_bit_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            q_beat0_reg <= '0;
            q_beat1_reg <= '0;
            dq_reg <= '0;
            b1_hold_reg <= '0;
            state_reg <= ST_IDLE;
        end else begin
            fetch_reg <= fetch_next;
            rd_bit_reg <= rd_bit_next;
            rd_pend_reg <= rd_pend_next;
            q_beat0_reg <= q_beat0_next;
            q_beat1_reg <= q_beat1_next;
            dq_reg <= dq_next;
            b1_hold_reg <= b1_hold_next;
            state_reg <= state_next;
        end
    end

    assign dq_o = dq_reg;
    assign dq_oe_o = (state_reg != ST_IDLE);

    // ------------------------------------------------------------------------
    // Echo strobes
    // ------------------------------------------------------------------------
    // Free running, so they are not held in reset
    logic echo_reg, echo_next, echo_n_reg, echo_n_next;

    always_comb begin
        echo_next = single ? clk_s2_reg.cap_clk : clk_s2_reg.out_clk;
        echo_n_next = single ? clk_s2_reg.cap_clk_n : clk_s2_reg.out_clk_n;
    end

    always_ff @(posedge ref_clk_i) begin
        echo_reg <= echo_next;
        echo_n_reg <= echo_n_next;
    end

    assign echo_strobe_o = echo_reg;
    assign echo_strobe_n_o = echo_n_reg;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_read_load;
        read_load;
    endsequence
    sequence s_fetched;
        ##1 fetch_reg ##1 rd_pend_reg;
    endsequence

    a_read_fetch_pend: assert property (s_read_load |-> s_fetched)
        else $error("read load did not raise a pending read in two cycles");
    a_deselect_quiet: assert property ((k_rise && pin_s2_reg.load_strobe_n && !wr_pend_reg)
            |-> (arr_en == '0) ##1 !fetch_reg)
        else $error("deselected cycle started an access");
    a_write_first_beat: assert property (write_load |-> arr_we[pin_s2_reg.addr[0]]
            && (lane_we == ~pin_s2_reg.byte_write_select_n)
            && (arr_idx == pin_s2_reg.addr[ADDR_W-1:1]))
        else $error("first write beat not stored with its selects");
    a_write_second_beat: assert property ((wr_pend_reg && kn_rise && !k_rise)
            |-> arr_we[~wr_addr_reg[0]] && !arr_we[wr_addr_reg[0]])
        else $error("second write beat went to the wrong array");
    a_beat0_drive: assert property ((out_rise0 && rd_pend_reg && state_reg != ST_BEAT0)
            |=> dq_oe_o && (dq_o == $past(q_beat0_reg)) && state_reg == ST_BEAT0)
        else $error("first read beat not driven on output edge");
    a_beat1_drive: assert property ((state_reg == ST_BEAT0 && out_rise1)
            |=> dq_oe_o && (dq_o == $past(b1_hold_reg)))
        else $error("second read beat not driven on complementary edge");
    a_beat1_parked: assert property (consume |=> (b1_hold_reg == $past(q_beat1_reg)))
        else $error("second read beat not parked when first beat left");
    a_tristate_idle: assert property ((state_reg == ST_BEAT1 && out_rise0 && !rd_pend_reg)
            |=> !dq_oe_o)
        else $error("data outputs not released after burst");
    a_idle_no_drive: assert property ((state_reg == ST_IDLE && !rd_pend_reg) |=> !dq_oe_o)
        else $error("data driven with no read pending");
    a_echo_follow: assert property (##1 (echo_strobe_o == $past(single ? clk_s2_reg.cap_clk
            : clk_s2_reg.out_clk)))
        else $error("echo strobe not following its reference clock");
endmodule : bds_port

// [core/bds_pkg.sv]
// Constants, carrier types and helper function for the burst-of-two DDR SRAM port
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package bds_pkg;

    // ------------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------------
    localparam bit WIDE_VARIANT = 1'b0;
    localparam int LANE_W = 9;
    localparam int LANES = WIDE_VARIANT ? 4 : 2;
    localparam int DATA_W = LANE_W * LANES;
    localparam int ADDR_W = WIDE_VARIANT ? 19 : 20;
    localparam int ARRAYS = 2;
    localparam int IDX_W = ADDR_W - 1;
    localparam int ARRAY_DEPTH = 2 ** IDX_W;

    // ------------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic load_strobe_n;
        logic rd_wrn;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] byte_write_select_n;
        logic [DATA_W-1:0] data;
    } bds_pins_t;

    typedef struct packed {
        logic single_clock;
        logic cap_clk;
        logic cap_clk_n;
        logic out_clk;
        logic out_clk_n;
    } bds_clks_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BEAT0 = 3'b010,
        ST_BEAT1 = 3'b100
    } bds_out_state_t;

    // Address of a beat inside the burst: one-bit linear counter wraps
    function automatic logic [ADDR_W-1:0] bds_burst_addr(input logic [ADDR_W-1:0] a,
                                                         input logic beat);
        bds_burst_addr = {a[ADDR_W-1:1], a[0] ^ beat};
    endfunction : bds_burst_addr

endpackage : bds_pkg

// [core/bds_array.sv]
// One internal storage array with byte-lane writes and registered read data
`timescale 1ns/1ns
module bds_array #(
    parameter int WIDTH = 18,
    parameter int LANES = 2,
    parameter int DEPTH = 524288
) (
    // Clock
    input wire logic ref_clk_i,
    // Access
    input wire logic en_i,
    input wire logic we_i,
    input wire logic [LANES-1:0] lane_we_i,
    input wire logic [$clog2(DEPTH)-1:0] idx_i,
    input wire logic [WIDTH-1:0] wdata_i,
    output logic [WIDTH-1:0] rdata_o
);
    localparam int LW = WIDTH / LANES;

    logic [WIDTH-1:0] mem [DEPTH];

    // Lanes not enabled keep their old contents
    always_ff @(posedge ref_clk_i) begin
        if (en_i) begin
            if (we_i) begin
                for (int l = 0; l < LANES; l++) begin
                    if (lane_we_i[l]) begin
                        mem[idx_i][l*LW +: LW] <= wdata_i[l*LW +: LW];
                    end
                end
            end else begin
                rdata_o <= mem[idx_i];
            end
        end
    end
endmodule : bds_array

// [sim/bds_ctrl_model.sv]
// Controller model: drives the port's clock pins and request pins
`timescale 1ns/1ns
module bds_ctrl_model
    import bds_pkg::*;
(
    // Clock and mode
    input wire logic ref_clk_i,
    input wire logic single_i,
    // Request from the bench
    input wire logic req_i,
    input wire logic rd_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] d0_i,
    input wire logic [DATA_W-1:0] d1_i,
    input wire logic [LANES-1:0] bw0_i,
    input wire logic [LANES-1:0] bw1_i,
    output logic ack_o,
    output logic [2:0] ph_o,
    // Pins towards the port
    output bds_clks_t clks_o,
    output bds_pins_t pins_o
);
    logic k;
    logic wr1_reg;
    logic [DATA_W-1:0] d1_reg;
    logic [LANES-1:0] bw1_reg;
    // Each clock level lasts four reference cycles; pins move mid-level
    assign k = (ph_o < 3'h4);
    // Output clocks stand still in single clock mode
    assign clks_o = {single_i, k, ~k, k & ~single_i, ~k & ~single_i};
    initial begin
        ph_o = 3'h0;
        ack_o = 1'b0;
        wr1_reg = 1'b0;
        pins_o = '0;
        pins_o.load_strobe_n = 1'b1;
    end
    always @(posedge ref_clk_i) begin
        ph_o <= ph_o + 3'h1;
        ack_o <= 1'b0;
        if (ph_o == 3'h5) begin
            wr1_reg <= req_i & ~rd_i;
            d1_reg <= d1_i;
            bw1_reg <= bw1_i;
            ack_o <= req_i;
            pins_o.load_strobe_n <= ~req_i;
            if (req_i) begin
                pins_o.rd_wrn <= rd_i;
                pins_o.addr <= addr_i;
                pins_o.data <= d0_i;
                pins_o.byte_write_select_n <= bw0_i;
            end else begin
                // Idle pins churn so a port that wrongly listens is caught
                pins_o.rd_wrn <= ~pins_o.rd_wrn;
                pins_o.addr <= ~pins_o.addr;
                pins_o.data <= ~pins_o.data;
                pins_o.byte_write_select_n <= ~pins_o.byte_write_select_n;
            end
        end
        if (ph_o == 3'h1) begin
            pins_o.load_strobe_n <= 1'b1;
            pins_o.rd_wrn <= ~pins_o.rd_wrn;
            pins_o.addr <= ~pins_o.addr;
            pins_o.data <= wr1_reg ? d1_reg : ~pins_o.data;
            pins_o.byte_write_select_n <= wr1_reg ? bw1_reg : ~pins_o.byte_write_select_n;
        end
    end
endmodule : bds_ctrl_model

// [sim/test_bds_port.sv]
// Self-checking bench for the burst-of-two DDR SRAM port
`timescale 1ns/1ns
module test_bds_port;
    import bds_pkg::*;
    typedef struct {int per; logic [DATA_W-1:0] d0; logic [DATA_W-1:0] d1;} bds_note_t;
    logic ref_clk_i, resetn_i, single, req, rd_r, ack, echo_strobe_o, echo_strobe_n_o;
    logic dq_oe_o, live, echo_ok;
    logic [2:0] ph;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] w0_r, w1_r, dq_o;
    logic [LANES-1:0] b0_r, b1_r;
    bds_clks_t clks;
    bds_pins_t pins;
    logic [DATA_W-1:0] mem [bit [ADDR_W-1:0]];
    bds_note_t exp_q[$];
    bds_note_t cur;
    int per, checks, miscompares;
    int seed = 32'h0B669943;
    bds_ctrl_model u_ctrl (.ref_clk_i(ref_clk_i), .single_i(single), .req_i(req), .rd_i(rd_r),
        .addr_i(addr_r), .d0_i(w0_r), .d1_i(w1_r), .bw0_i(b0_r), .bw1_i(b1_r), .ack_o(ack),
        .ph_o(ph), .clks_o(clks), .pins_o(pins));
    bds_port u_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .clks_i(clks), .pins_i(pins),
        .dq_o(dq_o), .dq_oe_o(dq_oe_o), .echo_strobe_o(echo_strobe_o),
        .echo_strobe_n_o(echo_strobe_n_o));
    // ------------------------------------------------------------------------
    // Comparison and verdict
    // ------------------------------------------------------------------------
    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
        checks++;
        if (seen !== want) begin
            miscompares++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : chk
    task automatic conclude();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
        input logic [DATA_W-1:0] nw, input logic [LANES-1:0] bn);
        for (int l = 0; l < LANES; l++) if (!bn[l]) old[l*LANE_W +: LANE_W] = nw[l*LANE_W +: LANE_W];
        return old;
    endfunction : merge
    // ------------------------------------------------------------------------
    // Driver: one burst per load; reads leave a note for the watcher
    // ------------------------------------------------------------------------
    task automatic xfer(input logic rd, input logic [ADDR_W-1:0] a, input logic [LANES-1:0] b0,
        input logic [LANES-1:0] b1);
        int n;
        logic [DATA_W-1:0] d0, d1;
        bds_note_t note;
        d0 = $random(seed);
        d1 = $random(seed);
        req <= 1'b1;
        rd_r <= rd;
        addr_r <= a;
        w0_r <= d0;
        w1_r <= d1;
        b0_r <= b0;
        b1_r <= b1;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (ack !== 1'b1 && n < 40);
        if (n >= 40) begin
            miscompares++;
            conclude();
        end
        if (rd) begin
            note.per = per + 2;
            note.d0 = mem[a];
            note.d1 = mem[a ^ 1];
            exp_q.push_back(note);
        end else begin
            mem[a] = merge(mem[a], d0, b0);
            mem[a ^ 1] = merge(mem[a ^ 1], d1, b1);
        end
    endtask : xfer
    task automatic pass_run();
        logic [ADDR_W-1:0] a [6];
        for (int i = 0; i < 6; i++) begin
            a[i] = $random(seed);
            a[i][3:1] = i;
            xfer(1'b0, a[i], '0, '0);
        end
        // Partial rewrites keep the deselected lanes
        for (int i = 0; i < 3; i++) xfer(1'b0, a[i], $random(seed), $random(seed));
        @(posedge ref_clk_i);
        req <= 1'b0;
        repeat (24) @(posedge ref_clk_i);
        for (int i = 0; i < 6; i++) xfer(1'b1, a[i], '0, '0);
        xfer(1'b0, a[5], '0, $random(seed));
        xfer(1'b1, a[5], '0, '0);
        @(posedge ref_clk_i);
        req <= 1'b0;
        repeat (40) @(posedge ref_clk_i);
        chk(exp_q.size(), 0);
    endtask : pass_run
    // ------------------------------------------------------------------------
    // Watcher: read beats, bus release and echo strobes mid-window
    // ------------------------------------------------------------------------
    always @(negedge ref_clk_i) begin
        if (ph == 3'h0) per = per + 1;
        if (resetn_i === 1'b1 && per > 3) begin
            if (ph == 3'h5) begin
                if (echo_ok) chk(echo_strobe_o, 1'b1);
                if (echo_ok) chk(echo_strobe_n_o, 1'b0);
                live = (exp_q.size() > 0) && (exp_q[0].per == per);
                chk(dq_oe_o, live);
                if (live) cur = exp_q.pop_front();
                if (live) chk(dq_o, cur.d0);
            end
            if (ph == 3'h1 && live) begin
                if (echo_ok) chk(echo_strobe_o, 1'b0);
                chk(dq_oe_o, 1'b1);
                chk(dq_o, cur.d1);
            end
        end
    end
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        {resetn_i, single, req, rd_r, live, echo_ok} = '0;
        {addr_r, w0_r, w1_r, b0_r, b1_r} = '0;
        per = 0;
        repeat (5) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        repeat (16) @(posedge ref_clk_i);
        echo_ok = 1'b1;
        pass_run();
        echo_ok = 1'b0;
        single <= 1'b1;
        repeat (32) @(posedge ref_clk_i);
        echo_ok = 1'b1;
        pass_run();
        conclude();
    end
endmodule : test_bds_port
